//--- ssat_pkg.sv
// constants, register map and carrier types for the synchronous serial port
// How it works
// - internal clock period is (reload+1)*2 cycles
// - shift and secondary buffers hidden from software
// - buffer loads shifter; receive copies back
// - wakeup enable forces block mode off
// - bit 6 receive select, bit 3 MSB-first
// - clearing run aborts; software clears enable too
// - single and block transmit end at last rise
// - block receive ends after final RAM store
// - bit 4 selects single or block mode
// - clearing block bit pauses after current byte
// - external clock falling edge while stopped sets overrun
// - block overrun windows around first fetch, last store
// - interrupt when enable and a flag set
// - slave mode uses chip select; change stopped
// - residual count: 000 is eight, else 1-7
// - full duplex block only in block mode
// - byte gap of 0,1,2,4..64 clock periods, internal clock only
// - block bits are (X+1)*8 plus residual
// - block bytes move between RAM and buffer
package ssat_pkg;
	localparam int ADDR_W = 17;
	localparam logic [14:0] IDX_BAUD  = 15'h7F35;
	localparam logic [14:0] IDX_BYTE_GAP_SELECT = 15'h7F37;
	localparam logic [14:0] IDX_CTRL  = 15'h7F80;
	localparam logic [14:0] IDX_BUF   = 15'h7F82;
	localparam logic [ADDR_W-1:0] ADDR_BAUD  = {IDX_BAUD, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_BYTE_GAP_SELECT = {IDX_BYTE_GAP_SELECT, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CTRL  = {IDX_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_BUF   = {IDX_BUF, 2'h0};
	localparam logic [7:0] RST_BAUD  = 8'h00;
	localparam logic [7:0] RST_BYTE_GAP_SELECT = 8'h00;
	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [7:0] RST_BUF   = 8'h00;
	localparam logic [7:0] EXT_CLK_RELOAD = 8'h00;
	localparam logic [3:0] FULL_BYTE = 4'h8;
	// inserted serial clock periods per gap code
	localparam logic [7:0][6:0] GAP_PERIODS = {7'h40, 7'h20, 7'h10, 7'h08,
		7'h04, 7'h02, 7'h01, 7'h00};

	typedef struct packed {
		logic wakeupEnable;
		logic receiveSelect;
		logic runFlag;
		logic blockMode;
		logic msbFirst;
		logic clockCollisionFlag;
		logic transferDoneFlag;
		logic irqEnable;
	} ssat_ctrl_s;

	typedef struct packed {
		logic       selectSlaveMode;
		logic [2:0] residualBitCount;
		logic       fullDuplexBlock;
		logic [2:0] byteGapSelect;
	} ssat_byte_gap_select_s;

	typedef struct packed {
		logic       req;
		logic       wr;
		logic [7:0] wdata;
	} ssat_ram_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_START = 3'h1,
		ST_FETCH = 3'h2,
		ST_SHIFT = 3'h3,
		ST_STORE = 3'h4,
		ST_GAP   = 3'h5,
		ST_PAUSE = 3'h6
	} ssat_state_e;
endpackage

//--- ssat_serial_peer.sv
// serial peer model: shifts a byte out on falls, captures the data line on rises
module ssat_serial_peer (
	input  wire logic        clock,
	input  wire logic        sclk,
	input  wire logic        serDataOut,
	input  wire logic        active,
	input  wire logic        load,
	input  wire logic [7:0]  txByte,
	input  wire logic        extRun,
	output logic             sclkIn,
	output logic             serDataIn,
	output logic [15:0]      rxBits
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] txShift = 8'h00;
	logic       sclkPrev = 1'b1;
	initial begin
		sclkIn = 1'b1;
		serDataIn = 1'b0;
		rxBits = 16'h0000;
	end
	// link clock runs only when asked for, parks high otherwise
	always begin
		#80;
		sclkIn = extRun ? ~sclkIn : 1'b1;
	end
	always @(posedge clock) begin
		sclkPrev <= sclk;
		if (load) begin
			txShift <= txByte;
			rxBits <= 16'h0000;
		end else if (!active) begin
			// idle line never holds a stale value
			serDataIn <= ~serDataIn;
		end else if (sclkPrev && !sclk) begin
			serDataIn <= txShift[7];
			txShift <= {txShift[6:0], 1'b0};
		end else if (!sclkPrev && sclk) begin
			rxBits <= {rxBits[14:0], serDataOut};
		end
	end
endmodule

//--- ssat_serial_port.sv
// serial port: register slave, clock generator, shifter and block sequencer
//
// Local design decision: the Avalon-MM interface to the registers.
module ssat_serial_port (
	input  wire logic                      clock,
	input  wire logic                      arst_n,
	input  wire logic [ssat_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic      [31:0]               avs_readdata,
	output logic                           avs_waitrequest,
	output ssat_pkg::ssat_ram_s            ramReq,
	input  wire logic                      ramAck,
	input  wire logic [7:0]                ramRdata,
	input  wire logic [11:0]               xferCount,
	input  wire logic                      sclkIn,
	output logic                           sclkOut,
	output logic                           sclkOe,
	input  wire logic                      serDataIn,
	output logic                           serDataOut,
	output logic                           serDataOe,
	input  wire logic                      chipSelectIn_n,
	output logic                           irq
);
	import ssat_pkg::*;

	ssat_ctrl_s  ctrl_q, ctrl_d;
	ssat_byte_gap_select_s byte_gap_select_q, byte_gap_select_d;
	ssat_state_e st_q, st_d;
	logic [7:0]  baud_q, baud_d;
	logic [7:0]  buf_q, buf_d;
	logic [7:0]  secBuf_q, secBuf_d;
	logic [7:0]  shift_q, shift_d;
	logic [3:0]  bitCnt_q, bitCnt_d;
	logic [15:0] remain_q, remain_d;
	logic [7:0]  divCnt_q, divCnt_d;
	logic        sclkInt_q, sclkInt_d;
	logic [16:0] gapCnt_q, gapCnt_d;
	logic        dout_q, dout_d;
	logic        dataOe_q, dataOe_d;
	logic        firstByte_q, firstByte_d;
	logic        blockRun_q, blockRun_d;
	logic        resp_q, resp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [2:0]  sclkSync_q;
	logic [1:0]  dinSync_q;
	logic [1:0]  csSync_q;

	logic        extClk, csOk, extFall, extRise, divHit, intEdge;
	logic        clkFall, clkRise, ovrEvt, ovrWin, fetchNeeded, finish, regWr;
	logic [7:0]  shiftIn;
	logic [3:0]  snLen;
	logic [9:0]  period;
	logic [16:0] gapCycles;
	logic [15:0] blockBits;
	ssat_state_e nextWork, contSt;

	// pin synchronisers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sclkSync_q <= 3'h7;
			dinSync_q  <= 2'h0;
			csSync_q   <= 2'h3;
		end else begin
			sclkSync_q <= {sclkSync_q[1:0], sclkIn};
			dinSync_q  <= {dinSync_q[0], serDataIn};
			csSync_q   <= {csSync_q[0], chipSelectIn_n};
		end
	end

	assign extClk  = (baud_q == EXT_CLK_RELOAD);
	assign csOk    = !byte_gap_select_q.selectSlaveMode || !csSync_q[1];
	assign extFall = sclkSync_q[2] && !sclkSync_q[1] && csOk;
	assign extRise = !sclkSync_q[2] && sclkSync_q[1] && csOk;
	assign divHit  = (divCnt_q == baud_q);
	assign intEdge = (st_q == ST_SHIFT) && !extClk && divHit;
	assign clkFall = extClk ? extFall : (intEdge && sclkInt_q);
	assign clkRise = extClk ? extRise : (intEdge && !sclkInt_q);
	assign shiftIn = ctrl_q.msbFirst ? {shift_q[6:0], dinSync_q[1]}
		: {dinSync_q[1], shift_q[7:1]};
	assign snLen   = (byte_gap_select_q.residualBitCount == 3'h0) ? FULL_BYTE
		: {1'b0, byte_gap_select_q.residualBitCount};
	assign blockBits = {({1'b0, xferCount} + 13'h0001), 3'h0}
		+ {12'h000, snLen};
	assign period    = {({1'b0, baud_q} + 9'h001), 1'b0};
	assign gapCycles = {10'h000, GAP_PERIODS[byte_gap_select_q.byteGapSelect]}
		* {7'h00, period};
	assign fetchNeeded = !ctrl_q.receiveSelect || byte_gap_select_q.fullDuplexBlock;
	assign nextWork    = fetchNeeded ? ST_FETCH : ST_SHIFT;
	assign contSt = !ctrl_q.blockMode ? ST_PAUSE
		: (gapCycles != 17'h00000 && !extClk) ? ST_GAP : nextWork;
	assign ovrWin = !ctrl_q.runFlag || (st_q == ST_START)
		|| (blockRun_q && st_q == ST_FETCH && firstByte_q)
		|| (blockRun_q && st_q == ST_STORE && remain_q == 16'h0000);
	assign ovrEvt = extClk && extFall && ovrWin;
	assign regWr  = avs_write && resp_q && avs_byteenable[0];

	// register slave answers one cycle after the request appears
	assign avs_waitrequest = (avs_read || avs_write) && !resp_q;
	assign avs_readdata    = rdata_q;
	assign resp_d          = (avs_read || avs_write) && !resp_q;

	always_comb begin
		rdata_d = rdata_q;
		if (avs_read && !resp_q) begin
			case (avs_address)
				ADDR_BAUD:  rdata_d = {24'h000000, baud_q};
				ADDR_BYTE_GAP_SELECT: rdata_d = {24'h000000, byte_gap_select_q};
				ADDR_CTRL:  rdata_d = {24'h000000, ctrl_q};
				ADDR_BUF:   rdata_d = {24'h000000, buf_q};
				default:    rdata_d = 32'h00000000;
			endcase
		end
	end

	always_comb begin
		ramReq.req   = (st_q == ST_FETCH) || (st_q == ST_STORE);
		ramReq.wr    = (st_q == ST_STORE);
		ramReq.wdata = byte_gap_select_q.fullDuplexBlock ? secBuf_q : buf_q;
	end

	assign sclkOut    = sclkInt_q;
	assign sclkOe     = !extClk && !byte_gap_select_q.selectSlaveMode;
	assign serDataOut = dout_q;
	assign serDataOe  = dataOe_q;
	assign irq        = ctrl_q.irqEnable
		&& (ctrl_q.transferDoneFlag || ctrl_q.clockCollisionFlag);

	always_comb begin
		ctrl_d      = ctrl_q;
		byte_gap_select_d     = byte_gap_select_q;
		baud_d      = baud_q;
		buf_d       = buf_q;
		secBuf_d    = secBuf_q;
		shift_d     = shift_q;
		st_d        = st_q;
		bitCnt_d    = bitCnt_q;
		remain_d    = remain_q;
		gapCnt_d    = gapCnt_q;
		dout_d      = dout_q;
		dataOe_d    = ctrl_q.runFlag && csOk;
		firstByte_d = firstByte_q;
		blockRun_d  = blockRun_q;
		divCnt_d    = 8'h00;
		sclkInt_d   = 1'b1;
		finish      = 1'b0;
		if (regWr) begin
			case (avs_address)
				ADDR_BAUD:  baud_d = avs_writedata[7:0];
				ADDR_BYTE_GAP_SELECT: byte_gap_select_d = ssat_byte_gap_select_s'(avs_writedata[7:0]);
				ADDR_BUF:   buf_d = avs_writedata[7:0];
				ADDR_CTRL: begin
					ctrl_d = ssat_ctrl_s'(avs_writedata[7:0]);
					if (ctrl_d.wakeupEnable) begin
						ctrl_d.blockMode = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (st_q == ST_SHIFT) begin
			divCnt_d  = divHit ? 8'h00 : divCnt_q + 8'h01;
			sclkInt_d = divHit ? !sclkInt_q : sclkInt_q;
		end
		case (st_q)
			ST_IDLE: begin
				if (ctrl_q.runFlag) begin
					st_d = ST_START;
				end
			end
			ST_START: begin
				firstByte_d = 1'b1;
				blockRun_d  = ctrl_q.blockMode;
				remain_d    = blockBits;
				if (!ctrl_q.blockMode) begin
					shift_d = buf_q;
					st_d    = ST_SHIFT;
				end else begin
					st_d = nextWork;
				end
			end
			ST_FETCH: begin
				if (ramAck) begin
					buf_d       = ramRdata;
					shift_d     = ramRdata;
					firstByte_d = 1'b0;
					st_d        = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (clkFall) begin
					dout_d = ctrl_q.msbFirst ? shift_q[7] : shift_q[0];
				end
				if (clkRise) begin
					shift_d  = shiftIn;
					bitCnt_d = bitCnt_q - 4'h1;
					if (blockRun_q) begin
						remain_d = remain_q - 16'h0001;
					end
					if (bitCnt_q == 4'h1) begin
						if (!blockRun_q) begin
							if (ctrl_q.receiveSelect) begin
								buf_d = shiftIn;
							end
							finish = 1'b1;
						end else if (byte_gap_select_q.fullDuplexBlock) begin
							secBuf_d = shiftIn;
							st_d     = ST_STORE;
						end else if (ctrl_q.receiveSelect) begin
							buf_d = shiftIn;
							st_d  = ST_STORE;
						end else if (remain_q == 16'h0001) begin
							finish = 1'b1;
						end else begin
							st_d = contSt;
						end
					end
				end
			end
			ST_STORE: begin
				if (ramAck) begin
					if (remain_q == 16'h0000) begin
						finish = 1'b1;
					end else begin
						st_d = contSt;
					end
				end
			end
			ST_GAP: begin
				if (gapCnt_q <= 17'h00001) begin
					st_d = nextWork;
				end else begin
					gapCnt_d = gapCnt_q - 17'h00001;
				end
			end
			ST_PAUSE: begin
				if (ctrl_q.blockMode) begin
					st_d = nextWork;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (!ctrl_q.runFlag) begin
			st_d = ST_IDLE;
		end
		if (st_d == ST_SHIFT && st_q != ST_SHIFT) begin
			bitCnt_d = !blockRun_d ? snLen
				: (remain_d > 16'h0008) ? FULL_BYTE : remain_d[3:0];
		end
		if (st_d == ST_GAP && st_q != ST_GAP) begin
			gapCnt_d = gapCycles;
		end
		if (finish) begin
			ctrl_d.runFlag          = 1'b0;
			ctrl_d.transferDoneFlag = 1'b1;
			st_d                    = ST_IDLE;
		end
		if (ovrEvt) begin
			ctrl_d.clockCollisionFlag = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q      <= ssat_ctrl_s'(RST_CTRL);
			byte_gap_select_q     <= ssat_byte_gap_select_s'(RST_BYTE_GAP_SELECT);
			baud_q      <= RST_BAUD;
			buf_q       <= RST_BUF;
			secBuf_q    <= 8'h00;
			shift_q     <= 8'h00;
			st_q        <= ST_IDLE;
			bitCnt_q    <= 4'h0;
			remain_q    <= 16'h0000;
			divCnt_q    <= 8'h00;
			sclkInt_q   <= 1'b1;
			gapCnt_q    <= 17'h00000;
			dout_q      <= 1'b0;
			dataOe_q    <= 1'b0;
			firstByte_q <= 1'b0;
			blockRun_q  <= 1'b0;
			resp_q      <= 1'b0;
			rdata_q     <= 32'h00000000;
		end else begin
			ctrl_q      <= ctrl_d;
			byte_gap_select_q     <= byte_gap_select_d;
			baud_q      <= baud_d;
			buf_q       <= buf_d;
			secBuf_q    <= secBuf_d;
			shift_q     <= shift_d;
			st_q        <= st_d;
			bitCnt_q    <= bitCnt_d;
			remain_q    <= remain_d;
			divCnt_q    <= divCnt_d;
			sclkInt_q   <= sclkInt_d;
			gapCnt_q    <= gapCnt_d;
			dout_q      <= dout_d;
			dataOe_q    <= dataOe_d;
			firstByte_q <= firstByte_d;
			blockRun_q  <= blockRun_d;
			resp_q      <= resp_d;
			rdata_q     <= rdata_d;
		end
	end

	// half-period watch for the internal clock
	logic [7:0] halfCnt_q;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			halfCnt_q <= 8'h00;
		end else begin
			halfCnt_q <= (sclkInt_d != sclkInt_q) ? 8'h00 : halfCnt_q + 8'h01;
		end
	end

	default clocking dc @(posedge clock); endclocking
	default disable iff (!arst_n);

	a_half_period: assert property (
		clkRise && !extClk |-> halfCnt_q == baud_q)
		else $error("internal clock half period wrong");
	a_load_shift: assert property (
		st_q == ST_START && !ctrl_q.blockMode |=> shift_q == $past(buf_q))
		else $error("shift register not loaded from buffer");
	a_wakeup_single: assert property (
		ctrl_q.wakeupEnable |-> !ctrl_q.blockMode)
		else $error("block mode set with wakeup");
	a_tx_order: assert property (
		st_q == ST_SHIFT && clkFall
		|=> dout_q == ($past(ctrl_q.msbFirst) ? $past(shift_q[7]) : $past(shift_q[0])))
		else $error("wrong bit driven");
	a_abort_idle: assert property (
		$fell(ctrl_q.runFlag) && !$rose(ctrl_q.transferDoneFlag) |=> st_q == ST_IDLE)
		else $error("abort did not stop transfer");
	a_done_stop: assert property (
		$rose(ctrl_q.transferDoneFlag) |-> !ctrl_q.runFlag && st_q == ST_IDLE)
		else $error("done flag without stop");
	a_rx_after_store: assert property (
		$rose(ctrl_q.transferDoneFlag) && blockRun_q && ctrl_q.receiveSelect
		|-> $past(st_q) == ST_STORE && $past(ramAck))
		else $error("block receive ended before RAM store");
	a_pause_hold: assert property (
		st_q == ST_PAUSE && !ctrl_q.blockMode && ctrl_q.runFlag
		|=> st_q == ST_PAUSE && !$rose(ctrl_q.transferDoneFlag))
		else $error("pause not held");
	a_ovr_stopped: assert property (
		extClk && extFall && !ctrl_q.runFlag |=> ctrl_q.clockCollisionFlag)
		else $error("overrun missed while stopped");
	a_irq_gate: assert property (
		finish && ctrl_q.irqEnable && !regWr
		|=> irq)
		else $error("interrupt missing after transfer end");
	a_single_bits: assert property (
		st_q == ST_START && !ctrl_q.blockMode && ctrl_q.runFlag
		|=> bitCnt_q == (($past(byte_gap_select_q.residualBitCount) == 3'h0) ? 4'h8
		: {1'b0, $past(byte_gap_select_q.residualBitCount)}))
		else $error("single mode bit count wrong");
	a_block_total: assert property (
		st_q == ST_START && ctrl_q.blockMode
		|=> remain_q == (16'({4'h0, $past(xferCount)}) + 16'h0001) * 16'h0008
		+ ((byte_gap_select_q.residualBitCount == 3'h0) ? 16'h0008
		: 16'({1'b0, byte_gap_select_q.residualBitCount})))
		else $error("block bit total wrong");
	a_ram_hold: assert property (
		ramReq.req && !ramAck && ctrl_q.runFlag |=> ramReq.req && $stable(ramReq.wr))
		else $error("RAM request dropped before ack");

	c_single_done: cover property (!blockRun_q && $rose(ctrl_q.transferDoneFlag));
	c_block_pause: cover property (st_q == ST_PAUSE ##[1:1000] st_q == ST_FETCH);
	c_block_store: cover property (st_q == ST_STORE && ramAck);
	c_overrun: cover property ($rose(ctrl_q.clockCollisionFlag));
endmodule

//--- sync_serial_auto_transfer_tb.sv
// self-checking bench for the synchronous serial port
module sync_serial_auto_transfer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ssat_pkg::*;
	logic              clock = 1'b0;
	logic              arst_n = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic              rd = 1'b0;
	logic              wr = 1'b0;
	logic [31:0]       wdata = '0;
	logic [31:0]       rdata;
	logic              waitReq;
	ssat_ram_s         ramReq;
	logic              ramAck = 1'b0;
	logic [7:0]        ramRdata = 8'h00;
	logic [11:0]       xferCount = 12'h000;
	logic              sclkIn, sclkOut, sclkOe, serDataIn, serDataOut, serDataOe, irq;
	logic              peerOn = 1'b0;
	logic              peerLoad = 1'b0;
	logic              extRun = 1'b0;
	logic [7:0]        peerTx = 8'h00;
	logic [15:0]       rxBits;
	logic              chipSel_n = 1'b0;
	logic [15:0]       stored = 16'h0000;
	logic [7:0]        ramTab [2] = '{8'h3C, 8'hC3};
	logic [1:0]        ramWait = 2'h0;
	logic              sclkPrev = 1'b1;
	int                fetches = 0;
	int                cyc = 0;
	int                lastFall = 0;
	int                period = 0;
	int                num_errors = 0;
	int                checked = 0;
	wire               sclk = sclkOe ? sclkOut : sclkIn;

	always #2 clock = ~clock;

	ssat_serial_port dut (.clock(clock), .arst_n(arst_n), .avs_address(address),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF),
		.avs_readdata(rdata), .avs_waitrequest(waitReq), .ramReq(ramReq), .ramAck(ramAck),
		.ramRdata(ramRdata), .xferCount(xferCount), .sclkIn(sclkIn), .sclkOut(sclkOut),
		.sclkOe(sclkOe), .serDataIn(serDataIn), .serDataOut(serDataOut),
		.serDataOe(serDataOe), .chipSelectIn_n(chipSel_n), .irq(irq));
	ssat_serial_peer peer (.clock(clock), .sclk(sclk), .serDataOut(serDataOut),
		.active(peerOn), .load(peerLoad), .txByte(peerTx), .extRun(extRun),
		.sclkIn(sclkIn), .serDataIn(serDataIn), .rxBits(rxBits));

	// transfer controller stand-in, answers after a few cycles
	always @(posedge clock) begin
		ramWait <= (ramReq.req && !ramAck) ? ramWait + 2'h1 : 2'h0;
		ramAck <= ramReq.req && ramWait == 2'h2;
		if (ramReq.req && ramWait == 2'h2 && !ramReq.wr) begin
			ramRdata <= ramTab[fetches[0]];
			fetches <= fetches + 1;
		end
		if (ramReq.req && ramWait == 2'h2 && ramReq.wr) begin
			stored <= {stored[7:0], ramReq.wdata};
		end
	end
	// spacing of internal clock falls
	always @(posedge clock) begin
		sclkPrev <= sclkOut;
		cyc <= cyc + 1;
		if (sclkPrev && !sclkOut) begin
			period <= cyc - lastFall;
			lastFall <= cyc;
		end
	end

	task automatic conclude();
		if (num_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic isWr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		address <= a;
		wr <= isWr;
		rd <= !isWr;
		wdata <= {24'h000000, d};
		@(posedge clock);
		while (waitReq !== 1'b0 && n < 20) begin
			@(posedge clock);
			n++;
		end
		if (n == 20) begin
			num_errors++;
			conclude();
		end
		// answer edge: data taken, request released
		q = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr8(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		check(what, {8'h00, q}, {8'h00, e});
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge clock);
			n++;
		end
		if (n == 4000) begin
			num_errors++;
			conclude();
		end
		peerOn <= 1'b0;
		@(posedge clock);
	endtask
	task automatic peer_arm(input logic [7:0] b);
		peerTx <= b;
		peerLoad <= 1'b1;
		@(posedge clock);
		peerLoad <= 1'b0;
		peerOn <= 1'b1;
	endtask

	task automatic t_reset();
		rdchk("baud", ADDR_BAUD, RST_BAUD);
		rdchk("interval", ADDR_BYTE_GAP_SELECT, RST_BYTE_GAP_SELECT);
		rdchk("control", ADDR_CTRL, RST_CTRL);
		rdchk("buffer", ADDR_BUF, RST_BUF);
		rdchk("unmapped", ADDR_BUF + 17'h00008, 8'h00);
	endtask
	task automatic t_wakeup();
		wr8(ADDR_CTRL, 8'h90);
		rdchk("wakeup", ADDR_CTRL, 8'h80);
		wr8(ADDR_CTRL, 8'h10);
		rdchk("block bit", ADDR_CTRL, 8'h10);
		wr8(ADDR_CTRL, 8'h00);
	endtask
	task automatic t_single_tx();
		wr8(ADDR_BAUD, 8'h04);
		wr8(ADDR_BUF, 8'h55);
		peer_arm(8'h00);
		wr8(ADDR_CTRL, 8'h21);
		wait_irq();
		check("lsb first bits", rxBits[7:0], 8'hAA);
		check("clock period", period[15:0], 16'h000A);
		rdchk("tx end", ADDR_CTRL, 8'h03);
		check("irq on done", irq, 1'b1);
		wr8(ADDR_CTRL, 8'h00);
		check("irq cleared", irq, 1'b0);
	endtask
	task automatic t_single_rx();
		peer_arm(8'hA5);
		wr8(ADDR_CTRL, 8'h69);
		wait_irq();
		rdchk("rx byte", ADDR_BUF, 8'hA5);
		rdchk("rx end", ADDR_CTRL, 8'h4B);
		wr8(ADDR_CTRL, 8'h00);
	endtask
	task automatic t_overrun();
		wr8(ADDR_BAUD, EXT_CLK_RELOAD);
		extRun <= 1'b1;
		repeat (150) @(posedge clock);
		extRun <= 1'b0;
		repeat (60) @(posedge clock);
		rdchk("overrun", ADDR_CTRL, 8'h04);
		wr8(ADDR_CTRL, 8'h00);
		rdchk("overrun clear", ADDR_CTRL, 8'h00);
	endtask
	task automatic t_block_tx();
		int f0;
		f0 = fetches;
		wr8(ADDR_BAUD, 8'h04);
		wr8(ADDR_BYTE_GAP_SELECT, 8'h01);
		xferCount <= 12'h000;
		peer_arm(8'h00);
		wr8(ADDR_CTRL, 8'h39);
		wait_irq();
		check("block bits", rxBits, 16'h3CC3);
		check("fetch count", 16'(fetches - f0), 16'h0002);
		rdchk("block end", ADDR_CTRL, 8'h1B);
		wr8(ADDR_CTRL, 8'h00);
	endtask
	task automatic t_slave();
		wr8(ADDR_BYTE_GAP_SELECT, 8'h80);
		chipSel_n <= 1'b1;
		peer_arm(8'h96);
		wr8(ADDR_CTRL, 8'h69);
		extRun <= 1'b1;
		repeat (100) @(posedge clock);
		check("clock oe slave", sclkOe, 1'b0);
		check("data oe deselected", serDataOe, 1'b0);
		rdchk("deselected", ADDR_CTRL, 8'h69);
		wr8(ADDR_CTRL, 8'h48);
		rdchk("abort", ADDR_CTRL, 8'h48);
		extRun <= 1'b0;
		repeat (40) @(posedge clock);
		chipSel_n <= 1'b0;
		peer_arm(8'h96);
		wr8(ADDR_CTRL, 8'h69);
		@(posedge clock);
		check("data oe selected", serDataOe, 1'b1);
		extRun <= 1'b1;
		wait_irq();
		extRun <= 1'b0;
		rdchk("slave rx", ADDR_BUF, 8'h96);
		rdchk("slave end", ADDR_CTRL, 8'h4B);
		wr8(ADDR_CTRL, 8'h00);
		wr8(ADDR_BYTE_GAP_SELECT, 8'h00);
	endtask
	task automatic t_block_duplex();
		wr8(ADDR_BYTE_GAP_SELECT, 8'h09);
		peer_arm(8'hA5);
		wr8(ADDR_CTRL, 8'h79);
		repeat (30) @(posedge clock);
		wr8(ADDR_CTRL, 8'h69);
		repeat (120) @(posedge clock);
		rdchk("paused", ADDR_CTRL, 8'h69);
		wr8(ADDR_CTRL, 8'h79);
		wait_irq();
		check("duplex tx bits", rxBits, 16'h3CC3);
		check("duplex stored", stored, 16'hA500);
		rdchk("duplex end", ADDR_CTRL, 8'h5B);
		wr8(ADDR_CTRL, 8'h00);
	endtask

	initial begin
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_wakeup();
		t_single_tx();
		t_single_rx();
		t_overrun();
		t_slave();
		t_block_tx();
		t_block_duplex();
		conclude();
	end
endmodule
